/* rtl/timer_pkg.sv */
package timer_pkg;
    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NCH = 3;
    localparam int CW = 16;
    localparam int NFLAG = 3;
    localparam int PRE_W = 8;
    localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
    localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
    localparam logic [PRE_W-1:0] PRE_DIV_DEF = 8'h04;
    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [31:0] MAP_BASE = 32'hFFFFF1F0;
    localparam logic [31:0] MAP_SPAN = 32'h00000040;
    localparam logic [31:0] TIMER_CHAN_B_STATUS = 32'hFFFFF1F4;
    localparam logic [31:0] TIMER_CHAN_C_STATUS = 32'hFFFFF204;
    localparam logic [31:0] TIMER_CHAN_D_STATUS = 32'hFFFFF214;
    localparam logic [1:0] W_CTRL = 2'h0;
    localparam logic [1:0] W_STATUS = 2'h1;
    localparam logic [1:0] W_CMP0 = 2'h2;
    localparam logic [1:0] W_CMP1 = 2'h3;
    localparam logic [1:0] IRQ_BLK = 2'h3;
    localparam logic [1:0] W_IRQ_STATUS = 2'h0;
    localparam logic [1:0] W_IRQ_ENABLE = 2'h1;
    localparam logic [1:0] W_IRQ_CLEAR = 2'h2;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_INTERVAL = 1;
    localparam int F_CMP0 = 0;
    localparam int F_CMP1 = 1;
    localparam int F_OVF = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [PRE_W-1:0] pre_cnt;
        logic tick;
        logic [NCH-1:0] run;
        logic [NCH-1:0] interval;
        logic [NCH-1:0][CW-1:0] cnt;
        logic [NCH-1:0][CW-1:0] cmp0;
        logic [NCH-1:0][CW-1:0] cmp1;
        logic [NCH*NFLAG-1:0] flags;
        logic [NCH*NFLAG-1:0] irq_en;
        logic irq;
    } state_t;
endpackage : timer_pkg

/* rtl/timer_status_interval.sv */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// What this block does
// - compare0 match sets status bit zero
// - compare1 match sets status bit one
// - counter overflow sets status bit two
// - interval mode period from compare register one
module timer_status_interval
    import timer_pkg::*;
#(
    parameter logic [PRE_W-1:0] PRESCALE_DIV = PRE_DIV_DEF
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // ------------------------------------------------------------
    // address decode: {hit, block, word}
    // ------------------------------------------------------------
    function automatic logic [4:0] decode(input logic [31:0] a);
        logic [31:0] off;
        off = a - MAP_BASE;
        decode = {(a >= MAP_BASE) && (off < MAP_SPAN) && (a[1:0] == 2'h0),
                  off[5:4], off[3:2]};
    endfunction : decode

    state_t s;
    state_t n;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [4:0] wd;
        logic [4:0] rd;
        logic [NCH*NFLAG-1:0] ev;
        logic [NCH*NFLAG-1:0] clr;
        logic [CW-1:0] wv;
        int c;
        wd = decode(s.waddr);
        rd = decode(s_axi_araddr);
        ev = '0;
        clr = '0;
        wv = s.wdata[CW-1:0];
        c = 0;
        n = s;

        // prescaler output
        n.tick = (s.pre_cnt == PRESCALE_DIV - 8'h01);
        n.pre_cnt = n.tick ? PRE_ZERO : s.pre_cnt + 8'h01;

        // counters and match events
        for (int i = 0; i < NCH; i++)
        begin
            if (!s.run[i])
            begin
                n.cnt[i] = CNT_ZERO;
            end
            else if (s.tick)
            begin
                ev[i*NFLAG+F_CMP0] = (s.cnt[i] == s.cmp0[i]);
                ev[i*NFLAG+F_CMP1] = (s.cnt[i] == s.cmp1[i]);
                ev[i*NFLAG+F_OVF] = (s.cnt[i] == CNT_MAX);
                if (s.interval[i] && ev[i*NFLAG+F_CMP1])
                begin
                    n.cnt[i] = CNT_ZERO;
                end
                else
                begin
                    n.cnt[i] = s.cnt[i] + 16'h0001;
                end
            end
        end

        // write channels
        if (s.awready && s_axi_awvalid)
        begin
            n.aw_held = 1'b1;
            n.waddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid)
        begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (s.aw_held && s.w_held && !s.bvalid)
        begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_SLVERR;
            c = int'(wd[3:2]);
            if (wd[4] && wd[3:2] == IRQ_BLK)
            begin
                if (wd[1:0] == W_IRQ_ENABLE)
                begin
                    n.bresp = RESP_OKAY;
                    if (s.wstrb[0])
                    begin
                        n.irq_en = s.wdata[NCH*NFLAG-1:0];
                    end
                end
                else if (wd[1:0] == W_IRQ_CLEAR)
                begin
                    n.bresp = RESP_OKAY;
                    if (s.wstrb[0])
                    begin
                        clr = s.wdata[NCH*NFLAG-1:0];
                    end
                end
            end
            else if (wd[4])
            begin
                n.bresp = RESP_OKAY;
                wv = s.cmp0[c];
                if (wd[1:0] == W_CMP1)
                begin
                    wv = s.cmp1[c];
                end
                if (s.wstrb[0])
                begin
                    wv[7:0] = s.wdata[7:0];
                end
                if (s.wstrb[1])
                begin
                    wv[15:8] = s.wdata[15:8];
                end
                case (wd[1:0])
                    W_CTRL:
                    begin
                        if (s.wstrb[0])
                        begin
                            n.run[c] = s.wdata[CTRL_RUN];
                            n.interval[c] = s.wdata[CTRL_INTERVAL];
                        end
                    end
                    W_CMP0: n.cmp0[c] = wv;
                    W_CMP1: n.cmp1[c] = wv;
                    default: n.bresp = RESP_SLVERR;
                endcase
            end
        end
        n.awready = !n.aw_held && !n.bvalid;
        n.wready = !n.w_held && !n.bvalid;

        // sticky flags, a new event beats a clear
        n.flags = (s.flags & ~clr) | ev;
        n.irq = |(n.flags & n.irq_en);

        // read channel
        if (s.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid)
        begin
            n.rvalid = 1'b1;
            n.rdata = 32'h00000000;
            n.rresp = RESP_SLVERR;
            c = int'(rd[3:2]);
            if (rd[4] && rd[3:2] == IRQ_BLK)
            begin
                if (rd[1:0] == W_IRQ_STATUS)
                begin
                    n.rresp = RESP_OKAY;
                    n.rdata[NCH*NFLAG-1:0] = s.flags;
                end
                else if (rd[1:0] == W_IRQ_ENABLE)
                begin
                    n.rresp = RESP_OKAY;
                    n.rdata[NCH*NFLAG-1:0] = s.irq_en;
                end
            end
            else if (rd[4])
            begin
                n.rresp = RESP_OKAY;
                case (rd[1:0])
                    W_CTRL:
                    begin
                        n.rdata[CTRL_RUN] = s.run[c];
                        n.rdata[CTRL_INTERVAL] = s.interval[c];
                    end
                    W_STATUS: n.rdata[NFLAG-1:0] = s.flags[c*NFLAG +: NFLAG];
                    W_CMP0: n.rdata[CW-1:0] = s.cmp0[c];
                    default: n.rdata[CW-1:0] = s.cmp1[c];
                endcase
            end
        end
        n.arready = !n.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
        end
        else if (ce)
        begin
            s <= n;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rdata = s.rdata;
    assign irq = s.irq;

endmodule : timer_status_interval

/* testbench/timer_props.sv */
`timescale 1ns/1ps
module timer_props
    import timer_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic irq
);
    // ----
    // checks
    // ----
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_write_answer: assert property (
        wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    chk_read_answer: assert property (
        rd_taken |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_b_single: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_r_single: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_err_data: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");
    chk_irq_drop: assert property (
        $fell(irq) |-> s_axi_bvalid)
        else $error("interrupt dropped without a write");
endmodule : timer_props

/* testbench/timer_status_interval_tb.sv */
`timescale 1ns/1ps
module timer_status_interval_tb;
    import timer_pkg::*;
    // ----
    // bench
    // ----
    typedef struct {
        logic w;
        logic [31:0] a;
        logic [31:0] d;
        logic [1:0] r;
    } row_t;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, irq;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int bad_count = 0, checks_done = 0, cyc = 0, t0;
    // write flag, address, data, expected response
    row_t rows [12] = '{
        '{1'h0, 32'hFFFFF1F4, 32'h0, 2'h0},
        '{1'h0, 32'hFFFFF204, 32'h0, 2'h0},
        '{1'h0, 32'hFFFFF214, 32'h0, 2'h0},
        '{1'h1, 32'hFFFFF1F4, 32'h7, 2'h2},
        '{1'h0, 32'hFFFFF1F4, 32'h0, 2'h0},
        '{1'h0, 32'hFFFFF22C, 32'h0, 2'h2},
        '{1'h0, 32'hFFFFF228, 32'h0, 2'h2},
        '{1'h1, 32'hFFFFF1F8, 32'h3, 2'h0},
        '{1'h0, 32'hFFFFF1F8, 32'h3, 2'h0},
        '{1'h1, 32'hFFFFF1FC, 32'h7, 2'h0},
        '{1'h1, 32'hFFFFF224, 32'h2, 2'h0},
        '{1'h0, 32'hFFFFF224, 32'h2, 2'h0}};
    timer_status_interval #(.PRESCALE_DIV(8'h01)) timer_status_interval_i (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq);
    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : rd
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (n < lim && irq !== 1'h1)
        begin
            @(posedge aclk);
            n++;
        end
        if (irq !== 1'h1)
        begin
            bad_count++;
            $display("[ERR] %0t irq wait ran out", $time);
        end
    endtask : wait_irq
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    initial
    begin
        #900000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            else
                rd(rows[i].a);
            chk(32'(r), 32'(rows[i].r));
            if (!rows[i].w)
                chk(d, rows[i].d);
        end
        // byte lanes: upper byte only, into an idle compare register
        s_axi_wstrb <= 4'h2;
        wr(32'hFFFFF218, 32'h00005678);
        chk(32'(r), 32'h0);
        s_axi_wstrb <= 4'h3;
        rd(32'hFFFFF218);
        chk(d, 32'h00005600);
        // interval mode: period 8 ticks with compare register 1 at 7
        wr(32'hFFFFF1F0, 32'h3);
        wait_irq(50);
        t0 = cyc;
        wr(32'hFFFFF228, 32'h2);
        wait_irq(50);
        chk(cyc - t0, 32'h8);
        rd(32'hFFFFF1F4);
        chk(d, 32'h3);
        rd(32'hFFFFF1F0);
        chk(d, 32'h3);
        wr(32'hFFFFF224, 32'h0);
        wr(32'hFFFFF228, 32'h1FF);
        repeat (20) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd(32'hFFFFF220);
        chk(d, 32'h3);
        // overflow on channel c, clock enable low for 100 edges
        wr(32'hFFFFF1F0, 32'h0);
        wr(32'hFFFFF228, 32'h1FF);
        wr(32'hFFFFF224, 32'h20);
        t0 = cyc;
        wr(32'hFFFFF200, 32'h1);
        ce <= 1'h0;
        repeat (100) @(posedge aclk);
        ce <= 1'h1;
        wait_irq(70000);
        // 2 edges to start, 100 frozen, 65536 ticks, 1 edge to see irq
        chk(cyc - t0, {16'h0000, CNT_MAX} + 32'h68);
        rd(32'hFFFFF204);
        chk(d, 32'h7);
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd(32'hFFFFF204);
        chk(d, 32'h0);
        end_sim;
    end
endmodule : timer_status_interval_tb
bind timer_status_interval timer_props timer_props_i (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq);
